// ---- hdl/sac_defines.vh ----
// register map, field positions, reset values and timing counts for the converter control
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// register byte addresses
`define SAC_ADDR_STATUS_CONTROL 8'h3c
`define SAC_ADDR_RESULT 8'h40
`define SAC_ADDR_CLOCK_DIVIDE 8'h44
`define SAC_ADDR_PORT_DATA 8'h48
`define SAC_ADDR_PORT_DIR 8'h4c
`define SAC_ADDR_MODE 8'h50

// status/control fields
`define SAC_BIT_DONE 7
`define SAC_BIT_IRQ_EN 6
`define SAC_BIT_REPEAT 5
`define SAC_SEL_MSB 4
`define SAC_SEL_LSB 0
`define SAC_SEL_OFF 5'h1f
`define SAC_SEL_LAST_CH 5'h03

// clock divide field sits in bits 7:5
`define SAC_DIV_MSB 7
`define SAC_DIV_LSB 5
`define SAC_DIV_RESET 3'h0

// mode register bits: 0 wait, 1 stop
`define SAC_MODE_WAIT 0
`define SAC_MODE_STOP 1

// converter clocks per conversion
`define SAC_CONV_CLOCKS 16

// axi response codes
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// ---- hdl/sac_clock_divider.v ----
// prescaler that turns the bus clock into a one-cycle converter clock enable
`timescale 1ns/100ps
module sac_clock_divider (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire restart,
    input wire run,
    input wire [2:0] div_code,
    // output
    output wire tick
);
    reg [3:0] count_r;
    reg [3:0] limit;

    // divide by 1, 2, 4, 8, or 16 when the top bit is set
    always @* begin
        case (div_code)
            3'h0: limit = 4'h0;
            3'h1: limit = 4'h1;
            3'h2: limit = 4'h3;
            3'h3: limit = 4'h7;
            default: limit = 4'hf;
        endcase
    end

    assign tick = run && !restart && (count_r >= limit);

    // restart aligns the first edge with the last register write
    always @(posedge clk) begin
        if (reset || restart || !run) begin
            count_r <= 4'h0;
        end else if (count_r >= limit) begin
            count_r <= 4'h0;
        end else begin
            count_r <= count_r + 4'h1;
        end
    end
endmodule // sac_clock_divider

// ---- hdl/sac_converter_control.v ----
// control of an 8-bit four-channel successive-approximation converter with axi4-lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sac_defines.vh"
module sac_converter_control (
    // clock and reset
    input wire clk,
    input wire reset,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // analog side: comparator and multiplexer
    input wire comparator_high,
    output reg [7:0] trial_code,
    output reg [1:0] selected_analog_input,
    output reg converter_power,
    output reg sample_hold,
    // port a pins 0, 1, 4, 5 (channels 0..3)
    input wire [3:0] port_pin_in,
    output wire [3:0] port_pin_out,
    output wire [3:0] port_pin_oe,
    // cpu low-power mode and interrupt
    output reg done_irq,
    output wire wake_request
);
    // state codes
    localparam ST_IDLE = 2'h0;
    localparam ST_CONVERT = 2'h1;

    // registers
    reg done_flag_r;
    reg done_irq_enable_r;
    reg repeat_convert_bit_r;
    reg [4:0] input_select_field_r;
    reg [2:0] converter_clock_divide_field_r;
    reg [3:0] port_data_r;
    reg [3:0] port_dir_r;
    reg wait_mode_r;
    reg stop_mode_r;
    reg [7:0] result_r;
    reg [1:0] state_r;
    reg [4:0] step_r;
    reg pending_r;
    reg [3:0] pin_meta_r;
    reg [3:0] pin_sync_r;
    reg [7:0] aw_addr_r;
    reg aw_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_held_r;

    wire conv_tick;
    wire converter_on;
    wire write_go;
    wire [7:0] wr_addr;
    wire ctl_write;
    wire result_read;
    wire read_go;
    wire conv_done;
    reg [3:0] chan_mask;
    reg [31:0] read_value;
    reg read_ok;
    reg [3:0] pin_read;
    integer i;

    // channel codes 0..3 only; all ones or unused codes drive no pin
    assign converter_on = (input_select_field_r != `SAC_SEL_OFF) && !stop_mode_r;
    always @* begin
        chan_mask = 4'h0;
        if (input_select_field_r <= `SAC_SEL_LAST_CH) begin
            chan_mask[input_select_field_r[1:0]] = 1'b1;
        end
    end

    // the selected pin is released as an input; the rest follow the port latches
    assign port_pin_out = port_data_r & ~chan_mask;
    assign port_pin_oe = port_dir_r & ~chan_mask;

    // pins come from outside, so two flops before anything reads them
    always @(posedge clk) begin
        if (reset) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= port_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // read value of the port: selected pin shows 0 or the data latch
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            if (chan_mask[i]) begin
                pin_read[i] = port_dir_r[i] ? port_data_r[i] : 1'b0;
            end else if (port_dir_r[i]) begin
                pin_read[i] = port_data_r[i];
            end else begin
                pin_read[i] = pin_sync_r[i];
            end
        end
    end

    // write channel: address and data taken in either order, held until both present
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign write_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_addr = aw_addr_r;
    assign ctl_write = write_go && (wr_addr == `SAC_ADDR_STATUS_CONTROL) && w_strb_r[0];

    always @(posedge clk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SAC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (write_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `SAC_ADDR_STATUS_CONTROL || wr_addr == `SAC_ADDR_CLOCK_DIVIDE ||
                    wr_addr == `SAC_ADDR_PORT_DATA || wr_addr == `SAC_ADDR_PORT_DIR ||
                    wr_addr == `SAC_ADDR_MODE || wr_addr == `SAC_ADDR_RESULT) begin
                    s_axi_bresp <= `SAC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SAC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software-written registers; result register ignores writes
    always @(posedge clk) begin
        if (reset) begin
            done_irq_enable_r <= 1'b0;
            repeat_convert_bit_r <= 1'b0;
            input_select_field_r <= `SAC_SEL_OFF;
            converter_clock_divide_field_r <= `SAC_DIV_RESET;
            port_data_r <= 4'h0;
            port_dir_r <= 4'h0;
            wait_mode_r <= 1'b0;
            stop_mode_r <= 1'b0;
        end else if (write_go && w_strb_r[0]) begin
            if (wr_addr == `SAC_ADDR_STATUS_CONTROL) begin
                done_irq_enable_r <= w_data_r[`SAC_BIT_IRQ_EN];
                repeat_convert_bit_r <= w_data_r[`SAC_BIT_REPEAT];
                input_select_field_r <= w_data_r[`SAC_SEL_MSB:`SAC_SEL_LSB];
            end else if (wr_addr == `SAC_ADDR_CLOCK_DIVIDE) begin
                converter_clock_divide_field_r <= w_data_r[`SAC_DIV_MSB:`SAC_DIV_LSB];
            end else if (wr_addr == `SAC_ADDR_PORT_DATA) begin
                port_data_r <= w_data_r[3:0];
            end else if (wr_addr == `SAC_ADDR_PORT_DIR) begin
                port_dir_r <= w_data_r[3:0];
            end else if (wr_addr == `SAC_ADDR_MODE) begin
                wait_mode_r <= w_data_r[`SAC_MODE_WAIT];
                stop_mode_r <= w_data_r[`SAC_MODE_STOP];
            end
        end
    end

    // converter clock enable; restarted by each control write
    sac_clock_divider u_divider (
        .clk(clk),
        .reset(reset),
        .restart(ctl_write),
        .run(converter_on),
        .div_code(converter_clock_divide_field_r),
        .tick(conv_tick)
    );

    // sequencer: step 0 samples, steps 2..9 resolve bits, done on the sixteenth clock
    assign conv_done = (state_r == ST_CONVERT) && conv_tick && (step_r == 5'd15);

    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            step_r <= 5'h00;
            pending_r <= 1'b0;
            trial_code <= 8'h80;
            result_r <= 8'h00;
            sample_hold <= 1'b0;
        end else if (ctl_write) begin
            // abandon any conversion and arm a fresh start on the new channel
            state_r <= ST_IDLE;
            step_r <= 5'h00;
            pending_r <= 1'b1;
            sample_hold <= 1'b0;
        end else if (!converter_on) begin
            state_r <= ST_IDLE;
            step_r <= 5'h00;
            sample_hold <= 1'b0;
            pending_r <= pending_r || (state_r == ST_CONVERT); // aborted work restarts on exit
        end else if (conv_tick) begin
            case (state_r)
                ST_IDLE: begin
                    if (pending_r) begin
                        pending_r <= 1'b0;
                        state_r <= ST_CONVERT;
                        step_r <= 5'h01;
                        sample_hold <= 1'b1;
                        trial_code <= 8'h80;
                    end
                end
                ST_CONVERT: begin
                    if (step_r >= 5'd2 && step_r <= 5'd9) begin
                        // comparator high keeps the bit; clamps fall out naturally
                        trial_code <= sar_next(trial_code, step_r[3:0], comparator_high);
                    end
                    if (step_r == 5'd15) begin
                        result_r <= trial_code;
                        step_r <= 5'h00;
                        sample_hold <= 1'b0;
                        if (repeat_convert_bit_r) begin
                            state_r <= ST_CONVERT;
                            step_r <= 5'h00;
                            trial_code <= 8'h80;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end else begin
                        step_r <= step_r + 5'h01;
                        if (step_r == 5'h00) begin
                            sample_hold <= 1'b1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // one bit decided per step 2..9, msb first; next trial bit set below it
    function [7:0] sar_next;
        input [7:0] code;
        input [3:0] step;
        input keep;
        reg [2:0] pos;
        reg [7:0] v;
        begin
            pos = 3'h7 - step[2:0] + 3'h2;
            v = code;
            v[pos] = keep;
            if (pos != 3'h0) begin
                v[pos - 3'h1] = 1'b1;
            end
            sar_next = v;
        end
    endfunction

    // analog mux follows the select field; power follows the select field and the stop mode bit
    always @(posedge clk) begin
        if (reset) begin
            selected_analog_input <= 2'h0;
            converter_power <= 1'b0;
        end else begin
            selected_analog_input <= input_select_field_r[1:0];
            converter_power <= converter_on;
        end
    end

    // read channel decode
    assign s_axi_arready = !s_axi_rvalid;
    assign read_go = s_axi_arvalid && s_axi_arready;
    assign result_read = read_go && (s_axi_araddr == `SAC_ADDR_RESULT);

    always @* begin
        read_ok = 1'b1;
        read_value = 32'h0000_0000;
        if (s_axi_araddr == `SAC_ADDR_STATUS_CONTROL) begin
            read_value[`SAC_BIT_DONE] = done_flag_r && !done_irq_enable_r;
            read_value[`SAC_BIT_IRQ_EN] = done_irq_enable_r;
            read_value[`SAC_BIT_REPEAT] = repeat_convert_bit_r;
            read_value[`SAC_SEL_MSB:`SAC_SEL_LSB] = input_select_field_r;
        end else if (s_axi_araddr == `SAC_ADDR_RESULT) begin
            read_value[7:0] = result_r;
        end else if (s_axi_araddr == `SAC_ADDR_CLOCK_DIVIDE) begin
            read_value[`SAC_DIV_MSB:`SAC_DIV_LSB] = converter_clock_divide_field_r;
        end else if (s_axi_araddr == `SAC_ADDR_PORT_DATA) begin
            read_value[3:0] = pin_read;
        end else if (s_axi_araddr == `SAC_ADDR_PORT_DIR) begin
            read_value[3:0] = port_dir_r;
        end else if (s_axi_araddr == `SAC_ADDR_MODE) begin
            read_value[`SAC_MODE_WAIT] = wait_mode_r;
            read_value[`SAC_MODE_STOP] = stop_mode_r;
        end else begin
            read_ok = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SAC_RESP_OKAY;
        end else if (read_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_value;
            s_axi_rresp <= read_ok ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // completion: flag or interrupt; a new completion beats a same-cycle result read, but a control write clears the interrupt
    always @(posedge clk) begin
        if (reset) begin
            done_flag_r <= 1'b0;
            done_irq <= 1'b0;
        end else begin
            if (conv_done && !done_irq_enable_r) begin
                done_flag_r <= 1'b1;
            end else if (result_read || done_irq_enable_r) begin
                done_flag_r <= 1'b0;
            end
            if (conv_done && done_irq_enable_r && !ctl_write) begin
                done_irq <= 1'b1;
            end else if (result_read || ctl_write) begin
                done_irq <= 1'b0;
            end
        end
    end

    // wait mode leaves the converter running; the interrupt wakes the cpu
    assign wake_request = wait_mode_r && done_irq;
endmodule // sac_converter_control

// ---- bench/sac_analog_model.sv ----
// behavioural analog front end: channel multiplexer and comparator
`timescale 1ns/100ps
module sac_analog_model (
    // clock
    input wire clk,
    // converter side
    input wire [7:0] trial_code,
    input wire [1:0] selected_analog_input,
    input wire sample_hold,
    input wire converter_power,
    // per-channel input levels, channel 0 in the low byte
    input wire [31:0] levels,
    output logic comparator_high
);
    logic noise_r = 1'b0;
    wire [7:0] vin = levels[{selected_analog_input, 3'b000} +: 8];
    // outside a conversion the comparator is not held, so stray sampling shows up
    always @(posedge clk) begin
        noise_r <= ~noise_r;
    end
    // full-scale input compares high even at code ff, ground never above code 00
    assign comparator_high = (sample_hold && converter_power) ? (vin >= trial_code) : noise_r;
endmodule // sac_analog_model

// ---- bench/sac_converter_control_chk.sv ----
// port-level assertions for the converter control block
`timescale 1ns/100ps
module sac_converter_control_chk (
    // clock and reset
    input wire clk,
    input wire reset,
    // register bus
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid, s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid, s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid, s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid, s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid, s_axi_rready,
    // analog side, pins and low-power outputs
    input wire comparator_high,
    input wire [7:0] trial_code,
    input wire [1:0] selected_analog_input,
    input wire converter_power, sample_hold,
    input wire [3:0] port_pin_in, port_pin_out, port_pin_oe,
    input wire done_irq, wake_request
);
    // mapped register addresses answer okay, all others slverr
    wire ar_mapped = s_axi_araddr inside {8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_wake_needs_irq: assert property (wake_request |-> done_irq)
        else $error("wake request without interrupt");
    chk_irq_clear_cause: assert property ($fell(done_irq) |-> $past(reset) || $past(s_axi_arvalid)
        || $past(s_axi_arvalid, 2) || $past(s_axi_wvalid, 2))
        else $error("interrupt dropped without read or control write");
    chk_irq_after_conv: assert property ($rose(done_irq) |-> $past(sample_hold))
        else $error("interrupt without a conversion");
    // the mux select lags the pin mask by one flop, so compare against last cycle's enables
    chk_sel_pin_input: assert property (converter_power && $past(converter_power)
        && $stable(selected_analog_input) |-> !$past(port_pin_oe[selected_analog_input]))
        else $error("selected pin still driven");
    chk_read_resp_map: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rresp == ($past(ar_mapped) ? 2'h0 : 2'h2))
        else $error("read response code wrong");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    cover property ($rose(done_irq));
    cover property (wake_request);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // sac_converter_control_chk

bind sac_converter_control sac_converter_control_chk u_chk (.*);

// ---- bench/sac_converter_control_bench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/100ps
module sac_converter_control_bench;
    // clock, reset and driven inputs
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, port_pin_in = 4'ha;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] levels = 32'hff00;
    // design outputs
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire comparator_high, converter_power, sample_hold, done_irq, wake_request;
    wire [1:0] s_axi_bresp, s_axi_rresp, selected_analog_input;
    wire [31:0] s_axi_rdata;
    wire [7:0] trial_code;
    wire [3:0] port_pin_out, port_pin_oe;
    // expectation queues and counters
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int err_total = 0;
    int samples_checked = 0;
    int seed = 3;
    int t0, t, c;

    sac_converter_control DUT (.*);
    sac_analog_model u_analog (.clk(clk), .trial_code(trial_code),
        .selected_analog_input(selected_analog_input), .sample_hold(sample_hold),
        .converter_power(converter_power), .levels(levels), .comparator_high(comparator_high));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // answers are paired with the oldest note; sampled mid-cycle, clear of edge updates
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    end

    // ready is raised only after the answer shows, so the hold logic is exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, bv, fin;
        int n;
        fin = 1'b0;
        n = 0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!fin && n < 300) begin
            @(negedge clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bv = s_axi_bvalid;
            fin = s_axi_bvalid & s_axi_bready;
            @(posedge clk);
            n++;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            s_axi_bready <= bv & !fin;
        end
        if (!fin) err_total++;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        logic ta, rv, fin;
        int n;
        fin = 1'b0;
        n = 0;
        rq.push_back(exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!fin && n < 300) begin
            @(negedge clk);
            ta = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid;
            fin = s_axi_rvalid & s_axi_rready;
            @(posedge clk);
            n++;
            if (ta) s_axi_arvalid <= 1'b0;
            s_axi_rready <= rv & !fin;
        end
        if (!fin) err_total++;
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        while (done_irq !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) err_total++;
        @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        levels[31:16] <= 16'($random(seed));
        @(posedge clk);
        rd(8'h3c, 34'h1f);
        rd(8'h44, 34'h0);
        rd(8'h60, {2'h2, 32'h0});
        wr(8'h60, 32'h0, 2'h2);
        check(converter_power, 1'b0);
        $display("reset and map test done");
        for (c = 0; c < 4; c++) begin
            wr(8'h3c, 32'h40 | c, 2'h0);
            wait_irq(t);
            check(selected_analog_input, c[1:0]);
            rd(8'h3c, 34'h40 | c);
            rd(8'h40, {26'h0, levels[c*8 +: 8]});
            check(done_irq, 1'b0);
        end
        $display("channel test done");
        for (c = 0; c < 8; c++) begin
            wr(8'h44, c << 5, 2'h0);
            wr(8'h3c, 32'h42, 2'h0);
            wait_irq(t);
            if (c == 0) t0 = t;
            check(t, t0 + 16 * ((c > 3 ? 16 : 1 << c) - 1));
            rd(8'h40, {26'h0, levels[23:16]});
        end
        wr(8'h44, 32'h0, 2'h0);
        $display("divider test done");
        wr(8'h3c, 32'h03, 2'h0);
        repeat (60) @(posedge clk);
        rd(8'h3c, 34'h83);
        rd(8'h40, {26'h0, levels[31:24]});
        rd(8'h3c, 34'h03);
        check(done_irq, 1'b0);
        $display("flag test done");
        wr(8'h3c, 32'h60, 2'h0);
        wait_irq(t);
        rd(8'h40, 34'h0);
        levels[7:0] <= 8'h5a;
        // let the conversion that straddles the level change finish, then one clean one
        repeat (33) @(posedge clk);
        wait_irq(t);
        rd(8'h40, 34'h5a);
        levels[7:0] <= 8'ha5;
        repeat (60) @(posedge clk);
        rd(8'h40, 34'ha5);
        wr(8'h3c, 32'h41, 2'h0);
        wait_irq(t);
        check(t, t0);
        rd(8'h40, 34'hff);
        repeat (60) @(posedge clk);
        check(done_irq, 1'b0);
        $display("continuous test done");
        wr(8'h48, 32'hf, 2'h0);
        wr(8'h4c, 32'h5, 2'h0);
        wr(8'h3c, 32'h0, 2'h0);
        check(port_pin_oe, 4'b0100);
        check(port_pin_out[2], 1'b1);
        rd(8'h48, 34'hf);
        wr(8'h3c, 32'h1, 2'h0);
        check(port_pin_oe, 4'b0101);
        rd(8'h48, 34'hd);
        wr(8'h4c, 32'hf, 2'h0);
        check(port_pin_oe, 4'b1101);
        $display("port test done");
        wr(8'h50, 32'h1, 2'h0);
        wr(8'h3c, 32'h43, 2'h0);
        wait_irq(t);
        check(wake_request, 1'b1);
        rd(8'h40, {26'h0, levels[31:24]});
        check(wake_request, 1'b0);
        wr(8'h50, 32'h0, 2'h0);
        $display("wait test done");
        wr(8'h3c, 32'h62, 2'h0);
        repeat (5) @(posedge clk);
        wr(8'h50, 32'h2, 2'h0);
        repeat (3) @(posedge clk);
        check({converter_power, sample_hold}, 2'b00);
        repeat (60) @(posedge clk);
        check(done_irq, 1'b0);
        wr(8'h50, 32'h0, 2'h0);
        wait_irq(t);
        check(t, t0);
        wr(8'h3c, 32'h42, 2'h0);
        wait_irq(t);
        check(t, t0);
        rd(8'h40, {26'h0, levels[23:16]});
        wr(8'h3c, 32'h1f, 2'h0);
        repeat (2) @(posedge clk);
        check(converter_power, 1'b0);
        $display("stop and power test done");
        end_of_test();
    end
endmodule // sac_converter_control_bench
